// ===== logic/rate_result_regs.v
// Rate configuration register, density pin and result status read-out.
// Assumes host I/O strobes are one-cycle pulses synchronous to clk.
//
// Contract
// (R01) Write-only rate register at 3F7, reset 10
// (R02) Software writes zero to reserved bits
// (R03) Model 30 stores precomp bit, read back
// (R04) Precomp bit survives software resets
// (R05) Density high on hardware reset only
// (R06) Status bytes shown through data register
// (R07) Status zero bits 7:6 termination code
// (R08) Status zero bit 5 seek end
// (R09) Status zero bit 4 home fault
// (R10) Bit3 zero, head, unit in status zero
// (R11) Status one bit 7 end of track
// (R12) Status one bit 5 CRC fault
// (R13) Status one bit 4 late service
// (R14) Status one bit 2 sector missing
// (R15) Status one bit 1 write blocked
// (R16) Status one bit 0 address mark missing
// (R17) Status one bits 6,3 read zero
// (R18) Rate bits hardware reset to 250 Kbps
// (R19) One shared rate from either register
`timescale 1ns/1ps
`include "rate_status_defs.vh"

module rate_result_regs (
  input  wire       clk,
  input  wire       nrst,
  input  wire [9:0] io_addr,
  input  wire [7:0] io_wdata,
  input  wire       io_wr,
  input  wire       io_rd,
  input  wire [1:0] reg_mode,
  input  wire       soft_reset,
  input  wire       alt_rate_wr,
  input  wire [1:0] alt_rate_data,
  input  wire       result_phase,
  input  wire       result_index,
  input  wire       cmd_start,
  input  wire [1:0] term_kind,
  input  wire       term_load,
  input  wire       seek_done,
  input  wire       recal_step,
  input  wire       home_track_input,
  input  wire       rel_seek_past_zero,
  input  wire       head_now,
  input  wire [1:0] unit_pick,
  input  wire       sector_past_end,
  input  wire       transfer_last,
  input  wire       rw_cmd_end,
  input  wire       crc_id_err,
  input  wire       crc_data_err,
  input  wire       service_late,
  input  wire       sector_miss,
  input  wire       write_cmd_active,
  input  wire       write_protect_in,
  input  wire       id_mark_miss_two_index,
  input  wire       data_mark_miss,
  output reg  [7:0] io_rdata,
  output wire       io_rvalid,
  output wire [1:0] data_rate,
  output wire       precomp_off_bit,
  output reg        density_out
);
  reg  [1:0] rate_r;
  reg        precomp_r;
  wire [7:0] status_zero;
  wire [7:0] status_one;
  wire       rate_hit = (io_addr == `RATE_CONFIG_ADDR);
  wire       data_hit = (io_addr == `DATA_REG_ADDR);
  wire       model30  = (reg_mode == `MODE_MODEL30);
  reg  [7:0] rdata_nxt;

  // Soft reset deliberately left out: rate and precomp must survive it
  always @(posedge clk) begin
    if (!nrst) begin
      rate_r    <= `RATE_RESET_VAL; // R18
      precomp_r <= `PRECOMP_RESET_VAL;
    end else begin
      if (io_wr && rate_hit) begin
        rate_r <= io_wdata[`RATE_PICK_HI_BIT:`RATE_PICK_LO_BIT]; // R01
        if (model30)
          precomp_r <= io_wdata[`PRECOMP_OFF_POS]; // R03
      end else if (alt_rate_wr) begin
        rate_r <= alt_rate_data; // R19
      end
    end
  end // R04

  // Density set high by hardware reset, then follows rate_r; soft resets are ignored
  always @(posedge clk) begin
    if (!nrst)
      density_out <= `DENSITY_RESET_VAL; // R05
    else
      density_out <= (rate_r == `RATE_RESET_VAL) || (rate_r == 2'h1);
  end

  assign data_rate       = rate_r;
  assign precomp_off_bit = precomp_r;

  status_builder u_status (
    .clk                    (clk),
    .nrst                   (nrst),
    .cmd_start              (cmd_start),
    .term_kind              (term_kind),
    .term_load              (term_load),
    .seek_done              (seek_done),
    .recal_step             (recal_step),
    .recal_home_seen        (home_track_input),
    .rel_seek_past_zero     (rel_seek_past_zero),
    .head_now               (head_now),
    .unit_pick              (unit_pick),
    .sector_past_end        (sector_past_end),
    .rw_end_no_last         (rw_cmd_end && !transfer_last),
    .crc_id_err             (crc_id_err),
    .crc_data_err           (crc_data_err),
    .service_late           (service_late),
    .sector_miss            (sector_miss),
    .write_cmd_active       (write_cmd_active),
    .write_protect_in       (write_protect_in),
    .id_mark_miss_two_index (id_mark_miss_two_index),
    .data_mark_miss         (data_mark_miss),
    .status_zero            (status_zero),
    .status_one             (status_one)
  );

  // Read side of 3F7 only reflects precomp in Model 30 mode
  always @* begin
    rdata_nxt = 8'h00;
    if (data_hit && result_phase)
      rdata_nxt = result_index ? status_one : status_zero; // R06
    else if (rate_hit && model30)
      rdata_nxt = {5'h00, precomp_r, rate_r}; // R03
  end

  always @(posedge clk) begin
    if (!nrst)
      io_rdata <= 8'h00;
    else if (io_rd)
      io_rdata <= rdata_nxt;
  end

  reg rvalid_r;
  always @(posedge clk) begin
    if (!nrst)
      rvalid_r <= 1'b0;
    else
      rvalid_r <= io_rd;
  end
  assign io_rvalid = rvalid_r;
  // soft_reset kept as a port for system wiring; nothing here clears on it
  wire unused_soft = soft_reset;
endmodule // rate_result_regs

// ===== include/rate_status_defs.vh
// Register offsets, field positions, reset values and codes for the
// floppy rate configuration and result status block.
// Assumes inclusion by bare name from the design files.
`ifndef RATE_STATUS_DEFS_VH
`define RATE_STATUS_DEFS_VH

`define RATE_CONFIG_ADDR     10'h3f7
`define DATA_REG_ADDR        10'h3f5
`define RATE_PICK_LO_BIT     0
`define RATE_PICK_HI_BIT     1
`define PRECOMP_OFF_POS      2
`define RATE_RESET_VAL       2'h2
`define PRECOMP_RESET_VAL    1'h0
`define DENSITY_RESET_VAL    1'h1
`define STEP_LIMIT           8'h50
`define TERM_NORMAL          2'h0
`define TERM_ABNORMAL        2'h1
`define TERM_INVALID         2'h2
`define TERM_POLLING         2'h3
`define MODE_AT              2'h0
`define MODE_PS2             2'h1
`define MODE_MODEL30         2'h2
`define TRACK_SECTOR_LAST    8'hff

`endif

// ===== logic/status_builder.v
// Assembles the two result status bytes from fault events.
// Assumes event inputs are one-cycle pulses synchronous to clk.
`timescale 1ns/1ps
`include "rate_status_defs.vh"

module status_builder (
  input  wire       clk,
  input  wire       nrst,
  input  wire       cmd_start,
  input  wire [1:0] term_kind,
  input  wire       term_load,
  input  wire       seek_done,
  input  wire       recal_step,
  input  wire       recal_home_seen,
  input  wire       rel_seek_past_zero,
  input  wire       head_now,
  input  wire [1:0] unit_pick,
  input  wire       sector_past_end,
  input  wire       rw_end_no_last,
  input  wire       crc_id_err,
  input  wire       crc_data_err,
  input  wire       service_late,
  input  wire       sector_miss,
  input  wire       write_cmd_active,
  input  wire       write_protect_in,
  input  wire       id_mark_miss_two_index,
  input  wire       data_mark_miss,
  output wire [7:0] status_zero,
  output wire [7:0] status_one
);
  reg [1:0] termination_code_r;
  reg       positioning_done_flag_r;
  reg       home_fault_flag_r;
  reg       end_track_r;
  reg       crc_fault_flag_r;
  reg       late_r;
  reg       sector_missing_flag_r;
  reg       write_blocked_flag_r;
  reg       id_sync_absent_flag_r;
  reg [7:0] step_cnt_r;

  // A step in the same cycle as a new command counts from zero
  wire [7:0] step_base   = cmd_start ? 8'h00 : step_cnt_r;
  wire       recal_fault = recal_step && !recal_home_seen &&
                           (step_base == `STEP_LIMIT - 8'h01);

  always @(posedge clk) begin
    if (!nrst) begin
      termination_code_r      <= `TERM_NORMAL;
      positioning_done_flag_r <= 1'b0;
      home_fault_flag_r       <= 1'b0;
      end_track_r             <= 1'b0;
      crc_fault_flag_r        <= 1'b0;
      late_r                  <= 1'b0;
      sector_missing_flag_r   <= 1'b0;
      write_blocked_flag_r    <= 1'b0;
      id_sync_absent_flag_r   <= 1'b0;
      step_cnt_r              <= 8'h00;
    end else begin
      // Per-command clear first, so an event in the same cycle still lands
      if (cmd_start) begin
        termination_code_r      <= `TERM_NORMAL;
        positioning_done_flag_r <= 1'b0;
        home_fault_flag_r       <= 1'b0;
        end_track_r             <= 1'b0;
        crc_fault_flag_r        <= 1'b0;
        late_r                  <= 1'b0;
        sector_missing_flag_r   <= 1'b0;
        write_blocked_flag_r    <= 1'b0;
        id_sync_absent_flag_r   <= 1'b0;
        step_cnt_r              <= 8'h00;
      end
      if (term_load)
        termination_code_r <= term_kind; // R07
      if (seek_done)
        positioning_done_flag_r <= 1'b1; // R08
      // Count recalibrate steps without home seen
      if (recal_step && !recal_home_seen && step_base != `STEP_LIMIT)
        step_cnt_r <= step_base + 8'h01;
      if (recal_fault || rel_seek_past_zero)
        home_fault_flag_r <= 1'b1; // R09
      if (sector_past_end || rw_end_no_last)
        end_track_r <= 1'b1; // R11
      if (crc_id_err || crc_data_err)
        crc_fault_flag_r <= 1'b1; // R12
      if (service_late)
        late_r <= 1'b1; // R13
      if (sector_miss)
        sector_missing_flag_r <= 1'b1; // R14
      if (write_cmd_active && write_protect_in)
        write_blocked_flag_r <= 1'b1; // R15
      if (id_mark_miss_two_index || data_mark_miss)
        id_sync_absent_flag_r <= 1'b1; // R16
    end
  end

  // Head and unit track live inputs
  assign status_zero = {termination_code_r, positioning_done_flag_r, home_fault_flag_r,
                        1'b0, head_now, unit_pick}; // R10
  assign status_one  = {end_track_r, 1'b0, crc_fault_flag_r, late_r, 1'b0,
                        sector_missing_flag_r, write_blocked_flag_r,
                        id_sync_absent_flag_r}; // R17
endmodule // status_builder

// ===== tb/rate_result_props.sv
// Assertion checker for the rate register and status read port.
// Assumes binding onto rate_result_regs, one clock, reset low.
`timescale 1ns/1ps
module rate_result_props (
  input wire       clk,
  input wire       nrst,
  input wire [9:0] io_addr,
  input wire [7:0] io_wdata,
  input wire       io_wr,
  input wire       io_rd,
  input wire [1:0] reg_mode,
  input wire       alt_rate_wr,
  input wire [1:0] alt_rate_data,
  input wire       result_phase,
  input wire       result_index,
  input wire [7:0] io_rdata,
  input wire       io_rvalid,
  input wire [1:0] data_rate,
  input wire       precomp_off_bit,
  input wire       density_out
);
  wire rw  = io_wr && io_addr == 10'h3f7;
  wire m30 = reg_mode == 2'h2;
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  sequence rate_wr_s; rw; endsequence
  sequence st_rd_s; io_rd && result_phase && io_addr == 10'h3f5; endsequence
  rate_set_a: assert property (rate_wr_s |=> data_rate == $past(io_wdata[1:0]))
    else $error("rate write lost");
  rate_alt_a: assert property (alt_rate_wr && !rw |=> data_rate == $past(alt_rate_data))
    else $error("alt rate lost");
  rate_keep_a: assert property (!rw && !alt_rate_wr |=> $stable(data_rate))
    else $error("rate moved");
  precomp_set_a: assert property (rw && m30 |=> precomp_off_bit == $past(io_wdata[2]))
    else $error("precomp lost");
  precomp_keep_a: assert property (!(rw && m30) |=> $stable(precomp_off_bit))
    else $error("precomp moved");
  density_keep_a: assert property ($stable(data_rate) |=> $stable(density_out))
    else $error("density moved");
  read_answer_a: assert property (io_rvalid == $past(io_rd))
    else $error("read answer late");
  status_bit3_a: assert property (st_rd_s |=> !io_rdata[3])
    else $error("status bit 3 set");
  status_bit6_a: assert property (st_rd_s ##0 result_index |=> !io_rdata[6])
    else $error("status bit 6 set");
endmodule // rate_result_props

// ===== tb/host_io_model.sv
// Host processor model issuing single-byte I/O port cycles.
// Assumes the block samples strobes on the rising edge of clk.
`timescale 1ns/1ps
module host_io_model (
  input  wire       clk,
  output reg  [9:0] io_addr,
  output reg  [7:0] io_wdata,
  output reg        io_wr,
  output reg        io_rd
);
  initial begin
    io_addr = 10'h0;
    io_wdata = 8'h0;
    io_wr = 1'b0;
    io_rd = 1'b0;
  end
  // Released lines flip so a stale value never looks valid
  task cyc(input [9:0] a, input [7:0] d, input w); begin
    @(posedge clk);
    io_addr <= a;
    io_wdata <= d & 8'h07;
    io_wr <= w;
    io_rd <= !w;
    @(posedge clk);
    io_wr <= 1'b0;
    io_rd <= 1'b0;
    io_addr <= ~a;
    io_wdata <= ~d;
  end endtask
endmodule // host_io_model

// ===== tb/floppy_rate_ctrl_result_status_tb_top.sv
// Testbench for rate configuration and result status read-out.
// Assumes host_io_model on the I/O port and the checker bound below.
`timescale 1ns/1ps
module floppy_rate_ctrl_result_status_tb_top;
  localparam [63:0] ST1_TAB = 64'h8020201001040201;
  reg         clk, nrst, rp, ri, tl;
  reg  [1:0]  mode, tk, ad;
  reg  [13:0] p;
  wire [9:0]  ia;
  wire [7:0]  iw, rdat;
  wire        iwr, ird, rv, pc, den;
  wire [1:0]  rate;
  wire [7:0]  pins = {4'h0, den, pc, rate};
  integer     n_fail, checked, i, n;
  always #10 clk = ~clk;
  host_io_model h (.clk(clk), .io_addr(ia), .io_wdata(iw), .io_wr(iwr), .io_rd(ird));
  rate_result_regs DUT (.clk(clk), .nrst(nrst), .io_addr(ia), .io_wdata(iw), .io_wr(iwr),
    .io_rd(ird), .reg_mode(mode), .soft_reset(p[12]), .alt_rate_wr(p[13]),
    .alt_rate_data(ad), .result_phase(rp), .result_index(ri), .cmd_start(p[8]),
    .term_kind(tk), .term_load(p[11]), .seek_done(p[9]), .recal_step(p[10]),
    .home_track_input(1'b0), .rel_seek_past_zero(1'b0), .head_now(1'b1), .unit_pick(2'h2),
    .sector_past_end(p[7]), .transfer_last(tl), .rw_cmd_end(p[0]), .crc_id_err(p[6]),
    .crc_data_err(p[5]), .service_late(p[4]), .sector_miss(p[2]), .write_cmd_active(rp),
    .write_protect_in(p[1]), .id_mark_miss_two_index(p[3]), .data_mark_miss(p[0]),
    .io_rdata(rdat), .io_rvalid(rv), .data_rate(rate), .precomp_off_bit(pc),
    .density_out(den));
  task chk(input [7:0] s, input [7:0] e); begin
    checked = checked + 1;
    if (s !== e) begin
      n_fail = n_fail + 1;
      $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
    end
  end endtask
  task give_verdict; begin
    $display("checked=%0d n_fail=%0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  end endtask
  task pulse(input [13:0] m); begin
    @(posedge clk);
    p <= m;
    @(posedge clk);
    p <= 14'h0;
  end endtask
  // Density trails the rate by one cycle
  task wrchk(input [7:0] d, input [7:0] e); begin
    h.cyc(10'h3f7, d, 1'b1);
    @(posedge clk) #1;
    chk(pins, e);
  end endtask
  task rdchk(input [9:0] a, input [7:0] e); begin
    h.cyc(a, 8'h0, 1'b0);
    #1;
    for (n = 0; n < 3 && rv !== 1'b1; n = n + 1) @(posedge clk) #1;
    if (n == 3) begin
      n_fail = n_fail + 1;
      give_verdict;
    end else
      chk(rdat, e);
  end endtask
  initial begin
    clk = 0; nrst = 0; p = 0; mode = 0; tk = 0; rp = 1; ri = 0; n_fail = 0; checked = 0;
    ad = 2'h3;
    tl = 1'b1;
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    #1 chk(pins, 8'h0a);
    for (i = 0; i < 4; i = i + 1) wrchk(i[7:0], {4'h0, i[1] ^ i[0], 1'b0, i[1:0]});
    $display("test rate done");
    @(posedge clk) mode <= 2'h2;
    wrchk(8'h05, 8'h0d);
    rdchk(10'h3f7, 8'h05);
    @(posedge clk) mode <= 2'h0;
    rdchk(10'h3f7, 8'h00);
    wrchk(8'h02, 8'h0e);
    pulse(14'h1000);
    #1 chk(pins, 8'h0e);
    pulse(14'h2000);
    @(posedge clk) #1 chk(pins, 8'h07);
    $display("test config done");
    // Hardware reset mid-run must restore rate, precomp and density
    @(posedge clk) nrst <= 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    #1 chk(pins, 8'h0a);
    for (i = 0; i < 5; i = i + 1) begin
      pulse(14'h0100);
      @(posedge clk) tk <= i[1:0];
      pulse(14'h0800);
      rdchk(10'h3f5, {i[1:0], 6'h06});
    end
    pulse(14'h0100);
    pulse(14'h0200);
    rdchk(10'h3f5, 8'h26);
    pulse(14'h0100);
    for (i = 0; i < 79; i = i + 1) pulse(14'h0400);
    rdchk(10'h3f5, 8'h06);
    pulse(14'h0400);
    rdchk(10'h3f5, 8'h16);
    @(posedge clk) ri <= 1'b1;
    for (i = 0; i < 8; i = i + 1) begin
      pulse(14'h0100);
      pulse(14'h1 << i);
      rdchk(10'h3f5, ST1_TAB[i*8 +: 8]);
    end
    // Read or write end without terminal count now also flags end of track
    @(posedge clk) tl <= 1'b0;
    pulse(14'h0100);
    pulse(14'h0001);
    rdchk(10'h3f5, 8'h81);
    $display("test status done");
    give_verdict;
  end
endmodule // floppy_rate_ctrl_result_status_tb_top
bind rate_result_regs rate_result_props props (.clk, .nrst, .io_addr, .io_wdata, .io_wr,
  .io_rd, .reg_mode, .alt_rate_wr, .alt_rate_data, .result_phase, .result_index, .io_rdata,
  .io_rvalid, .data_rate, .precomp_off_bit, .density_out);
